//--- core/byte_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wp;
    logic [AW:0]                 rp;
  } fifo_s;
  fifo_s r;
  fifo_s n;
  logic  full;
  logic  empty;
  assign full        = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
  assign empty       = (r.wp == r.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = r.mem[r.rp[AW-1:0]];
  always_comb begin
    n = r;
    if (in_valid_i && !full) begin
      n.mem[r.wp[AW-1:0]] = in_data_i;
      n.wp                = r.wp + 1'b1;
    end
    if (out_ready_i && !empty) begin
      n.rp = r.rp + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule // byte_fifo

//--- core/mon_pkg.sv
// constants shared by the monitor serial command port
package mon_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam logic [16:0] BAUD_DIV    = 17'h00116;
  localparam logic [3:0]  GAP_BITS    = 4'h2;
  localparam logic [3:0]  CANCEL_BITS = 4'hB;
  localparam logic [3:0]  FRAME_LAST  = 4'h9;
  localparam logic [3:0]  SEC_LAST    = 4'h7;
  localparam logic [1:0]  ENTRY_WAIT  = 2'h3;
  localparam logic [15:0] SEC_BASE    = 16'hFFF6;
  localparam logic [15:0] FLAG_ADDR   = 16'h0040;
  localparam logic [15:0] NVM_BASE    = 16'h8000;
  localparam logic [15:0] SP_OFS      = 16'h0001;
  localparam logic [15:0] PC_HI_OFS   = 16'h0005;
  localparam logic [15:0] PC_LO_OFS   = 16'h0006;
  localparam logic [7:0]  FLAG_MASK   = 8'h40;
  localparam logic [7:0]  BLANK       = 8'hFF;
  localparam logic [7:0]  INVALID     = 8'h00;
  localparam logic [7:0]  CMD_READ    = 8'h01;
  localparam logic [7:0]  CMD_WRITE   = 8'h02;
  localparam logic [7:0]  CMD_INDEXED_READ_CMD   = 8'h03;
  localparam logic [7:0]  CMD_INDEXED_WRITE_CMD  = 8'h04;
  localparam logic [7:0]  CMD_STACK_POINTER_READ_CMD  = 8'h05;
  localparam logic [7:0]  CMD_RUN     = 8'h06;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
endpackage

//--- core/monitor_serial_command_port.sv
// monitor command interpreter on a single-wire serial line
`timescale 1ns/1ps
module monitor_serial_command_port (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        sys_reset_i,
  input  wire logic        monitor_data_pin_i,
  output logic             monitor_data_pin_o,
  output logic             monitor_data_pin_oe_n_o,
  input  wire logic        test_entry_voltage_i,
  input  wire logic        divider_select_pin_i,
  input  wire logic        mass_erase_i,
  input  wire logic [15:0] sp_i,
  output logic [15:0]      mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic [7:0]       mem_wdata_o,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             run_o,
  output logic             illegal_reset_o,
  output logic             security_ok_o
);
  // ==========================================================
  // state
  typedef enum logic [4:0] {
    ENTRY, GET, ECHO_GAP, ECHO_TX, ECHO_WAIT, SEC_FLAG,
    BRK_HIGH, BRK_TX, BRK_WAIT, CANCEL, EXEC_RD,
    DATA_GAP, DATA_TX, DATA_WAIT, RUN_HI, RUN_LO, HALT
  } st_e;

  typedef struct packed {
    st_e         st;
    logic [1:0]  tv;
    logic [1:0]  dv;
    logic [1:0]  ent;
    logic        slow;
    logic        por_pend;
    logic        sec;
    logic        unlocked;
    logic        match;
    logic        erased;
    logic        cmp_pend;
    logic        have_cmd;
    logic        sp_mode;
    logic        rd_pend;
    logic [3:0]  idx;
    logic [1:0]  need;
    logic [1:0]  nout;
    logic [7:0]  cmd;
    logic [7:0]  data;
    logic [23:0] opnd;
    logic [15:0] ptr;
    logic [15:0] sp1;
    logic [7:0]  pc_hi;
    logic [16:0] wcnt;
    logic [3:0]  wbits;
    logic [15:0] maddr;
    logic        mrd;
    logic        mwr;
    logic [7:0]  mwd;
    logic        run;
    logic        ill;
  } mon_s;

  mon_s        r;
  mon_s        n;
  logic [16:0] bc;
  logic        wdone;
  logic        tx_start;
  logic        tx_busy;
  logic        hold_high;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  rx_data;
  logic        rx_break;
  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;
  logic [15:0] pc;

  // ==========================================================
  // decoding helpers
  function automatic logic nvm_locked(input logic [15:0] a, input logic u);
    nvm_locked = !u && (a >= mon_pkg::NVM_BASE);
  endfunction

  function automatic logic [1:0] op_count(input logic [7:0] c);
    unique case (c)
      mon_pkg::CMD_READ:   op_count = 2'h2;
      mon_pkg::CMD_WRITE:  op_count = 2'h3;
      mon_pkg::CMD_INDEXED_WRITE_CMD: op_count = 2'h1;
      default:             op_count = 2'h0;
    endcase
  endfunction

  // ==========================================================
  // line engine and receive buffer
  assign bc        = r.slow ? (mon_pkg::BAUD_DIV << 1) : mon_pkg::BAUD_DIV;
  assign wdone     = (r.wbits == '0);
  assign tx_start  = (r.st == ECHO_TX) || (r.st == DATA_TX) || (r.st == BRK_TX);
  assign hold_high = (r.st == BRK_HIGH);
  assign f_ready   = (r.st == GET);
  assign pc        = {r.pc_hi, mem_rdata_i};

  serial_line_engine u_line (
    .core_clk_i   (core_clk_i),
    .reset_n_i    (reset_n_i),
    .bit_cycles_i (bc),
    .line_i       (monitor_data_pin_i),
    .tx_start_i   (tx_start),
    .tx_break_i   (r.st == BRK_TX),
    .tx_data_i    (r.data),
    .hold_high_i  (hold_high),
    .line_o       (monitor_data_pin_o),
    .line_oe_n_o  (monitor_data_pin_oe_n_o),
    .tx_busy_o    (tx_busy),
    .rx_valid_o   (rx_valid),
    .rx_data_o    (rx_data),
    .rx_ready_i   (rx_ready),
    .rx_break_o   (rx_break)
  );

  byte_fifo #(
    .WIDTH (mon_pkg::BYTE_W),
    .DEPTH (mon_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (rx_valid),
    .in_ready_o  (rx_ready),
    .in_data_i   (rx_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // ==========================================================
  // interpreter
  always_comb begin
    n     = r;
    n.mrd = 1'b0;
    n.mwr = 1'b0;
    n.run = 1'b0;
    n.ill = 1'b0;
    n.tv  = {r.tv[0], test_entry_voltage_i};
    n.dv  = {r.dv[0], divider_select_pin_i};
    n.erased = r.erased | mass_erase_i;
    if (r.wbits != '0) begin
      if (r.wcnt == '0) begin
        n.wbits = r.wbits - 4'h1;
        n.wcnt  = bc - 17'h1;
      end else begin
        n.wcnt = r.wcnt - 17'h1;
      end
    end
    unique case (r.st)
      ENTRY: begin
        n.ent = r.ent + 2'h1;
        if (r.ent == mon_pkg::ENTRY_WAIT) begin
          n.slow     = r.tv[1] ? r.dv[1] : 1'b1;
          n.sec      = r.por_pend;
          n.por_pend = 1'b0;
          n.idx      = '0;
          n.match    = 1'b1;
          n.have_cmd = 1'b0;
          if (r.por_pend) begin
            n.st = GET;
          end else begin
            n.st    = BRK_HIGH;
            n.wbits = mon_pkg::GAP_BITS;
            n.wcnt  = bc - 17'h1;
          end
        end
      end
      GET: begin
        if (f_valid) begin
          n.data  = f_data;
          n.st    = ECHO_GAP;
          n.wbits = mon_pkg::GAP_BITS;
          n.wcnt  = bc - 17'h1;
          if (r.sec) begin
            n.maddr    = mon_pkg::SEC_BASE + {12'h000, r.idx};
            n.mrd      = 1'b1;
            n.cmp_pend = 1'b1;
          end else if (!r.have_cmd) begin
            n.cmd      = f_data;
            n.have_cmd = 1'b1;
            n.need     = op_count(f_data);
          end else begin
            n.opnd = {r.opnd[15:0], f_data};
            n.need = r.need - 2'h1;
          end
        end
      end
      ECHO_GAP: begin
        if (r.cmp_pend && !r.mrd) begin
          n.match    = r.match && ((r.erased ? mon_pkg::BLANK : mem_rdata_i) == r.data);
          n.cmp_pend = 1'b0;
        end
        if (wdone) n.st = ECHO_TX;
      end
      ECHO_TX: n.st = ECHO_WAIT;
      ECHO_WAIT: begin
        if (!tx_busy) begin
          if (r.sec) begin
            n.idx = r.idx + 4'h1;
            n.st  = (r.idx == mon_pkg::SEC_LAST) ? SEC_FLAG : GET;
          end else if (r.need != '0) begin
            n.st = GET;
          end else begin
            n.st    = CANCEL;
            n.wbits = mon_pkg::CANCEL_BITS;
            n.wcnt  = bc - 17'h1;
          end
        end
      end
      SEC_FLAG: begin
        n.sec   = 1'b0;
        n.st    = BRK_HIGH;
        n.wbits = mon_pkg::GAP_BITS;
        n.wcnt  = bc - 17'h1;
        if (r.match) begin
          n.unlocked = 1'b1;
          n.maddr    = mon_pkg::FLAG_ADDR;
          n.mwd      = mon_pkg::FLAG_MASK;
          n.mwr      = 1'b1;
        end
      end
      BRK_HIGH: begin
        if (wdone) n.st = BRK_TX;
      end
      BRK_TX: n.st = BRK_WAIT;
      BRK_WAIT: begin
        if (!tx_busy) begin
          n.st       = GET;
          n.have_cmd = 1'b0;
        end
      end
      CANCEL: begin
        if (wdone) begin
          n.have_cmd = 1'b0;
          n.sp_mode  = 1'b0;
          n.st       = GET;
          unique case (r.cmd)
            mon_pkg::CMD_READ: begin
              n.ptr  = r.opnd[15:0];
              n.nout = 2'h1;
              n.st   = EXEC_RD;
            end
            mon_pkg::CMD_WRITE: begin
              n.maddr = r.opnd[23:8];
              n.mwd   = r.opnd[7:0];
              n.mwr   = 1'b1;
              n.ptr   = r.opnd[23:8];
            end
            mon_pkg::CMD_INDEXED_READ_CMD: begin
              n.nout = 2'h2;
              n.st   = EXEC_RD;
            end
            mon_pkg::CMD_INDEXED_WRITE_CMD: begin
              n.maddr = r.ptr;
              n.mwd   = r.opnd[7:0];
              n.mwr   = 1'b1;
              n.ptr   = r.ptr + 16'h0001;
            end
            mon_pkg::CMD_STACK_POINTER_READ_CMD: begin
              n.sp1     = sp_i + mon_pkg::SP_OFS;
              n.sp_mode = 1'b1;
              n.nout    = 2'h2;
              n.st      = DATA_GAP;
              n.wbits   = mon_pkg::GAP_BITS;
              n.wcnt    = bc - 17'h1;
            end
            mon_pkg::CMD_RUN: begin
              n.maddr = sp_i + mon_pkg::PC_HI_OFS;
              n.mrd   = 1'b1;
              n.st    = RUN_HI;
            end
            default: n.st = GET;
          endcase
        end
      end
      EXEC_RD: begin
        n.maddr   = r.ptr;
        n.mrd     = 1'b1;
        n.rd_pend = 1'b1;
        n.ptr     = r.ptr + 16'h0001;
        n.st      = DATA_GAP;
        n.wbits   = mon_pkg::GAP_BITS;
        n.wcnt    = bc - 17'h1;
      end
      DATA_GAP: begin
        if (r.rd_pend && !r.mrd) begin
          n.data    = nvm_locked(r.maddr, r.unlocked) ? mon_pkg::INVALID : mem_rdata_i;
          n.rd_pend = 1'b0;
        end
        if (r.sp_mode) n.data = (r.nout == 2'h2) ? r.sp1[15:8] : r.sp1[7:0];
        if (wdone) n.st = DATA_TX;
      end
      DATA_TX: n.st = DATA_WAIT;
      DATA_WAIT: begin
        if (!tx_busy) begin
          n.nout = r.nout - 2'h1;
          if (r.nout == 2'h1) begin
            n.st = GET;
          end else if (r.sp_mode) begin
            n.st    = DATA_GAP;
            n.wbits = mon_pkg::GAP_BITS;
            n.wcnt  = bc - 17'h1;
          end else begin
            n.st = EXEC_RD;
          end
        end
      end
      RUN_HI: begin
        if (!r.mrd) begin
          n.pc_hi = mem_rdata_i;
          n.maddr = sp_i + mon_pkg::PC_LO_OFS;
          n.mrd   = 1'b1;
          n.st    = RUN_LO;
        end
      end
      RUN_LO: begin
        if (!r.mrd) begin
          n.st = HALT;
          if (nvm_locked(pc, r.unlocked)) begin
            n.ill = 1'b1;
          end else begin
            n.run = 1'b1;
          end
        end
      end
      HALT: n.st = HALT;
    endcase
    // a break outside security entry, ENTRY, BRK_HIGH and HALT cancels whatever is pending
    if (rx_break && !r.sec && (r.st != ENTRY) && (r.st != HALT) && (r.st != BRK_HIGH)) begin
      n.st       = BRK_HIGH;
      n.have_cmd = 1'b0;
      n.wbits    = mon_pkg::GAP_BITS;
      n.wcnt     = bc - 17'h1;
    end
    if (sys_reset_i) begin
      n.st  = ENTRY;
      n.ent = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r          <= '0;
      r.por_pend <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign mem_addr_o      = r.maddr;
  assign mem_rd_o        = r.mrd;
  assign mem_wr_o        = r.mwr;
  assign mem_wdata_o     = r.mwd;
  assign run_o           = r.run;
  assign illegal_reset_o = r.ill;
  assign security_ok_o   = r.unlocked;

  // ==========================================================
  // checks
  logic [17:0] gap_cnt;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_cnt <= '0;
    end else begin
      gap_cnt <= (r.st == ECHO_GAP) ? gap_cnt + 18'h1 : '0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_cancel;
    (r.st == CANCEL) && rx_break && !sys_reset_i |=> (r.st == BRK_HIGH);
  endproperty
  a_cancel: assert property (p_cancel) else $error("break did not cancel command");

  property p_echo_gap;
    (r.st == ECHO_TX) |-> (gap_cnt == {bc, 1'b0} + 18'h1);
  endproperty
  a_echo_gap: assert property (p_echo_gap) else $error("echo gap length wrong");

  property p_data_after_echo;
    (r.st == DATA_TX) |-> !tx_busy && ($past(r.st) != ECHO_TX);
  endproperty
  a_data_after_echo: assert property (p_data_after_echo) else $error("data overlaps echo");

  property p_sp_plus1;
    (r.st == CANCEL) && wdone && (r.cmd == mon_pkg::CMD_STACK_POINTER_READ_CMD) && !rx_break && !sys_reset_i
      |=> (r.sp1 == $past(sp_i) + 16'h0001);
  endproperty
  a_sp_plus1: assert property (p_sp_plus1) else $error("stack pointer not incremented");

  property p_illegal;
    (r.st == RUN_LO) && !r.mrd && !r.unlocked && (pc >= mon_pkg::NVM_BASE) && !sys_reset_i
      |=> illegal_reset_o && !run_o;
  endproperty
  a_illegal: assert property (p_illegal) else $error("locked execute not refused");

  property p_ready_after_sec;
    (r.st == BRK_TX) |-> !r.sec;
  endproperty
  a_ready_after_sec: assert property (p_ready_after_sec) else $error("break during security");

  property p_flag_write;
    (r.st == SEC_FLAG) && r.match && !sys_reset_i
      |=> mem_wr_o && (mem_addr_o == mon_pkg::FLAG_ADDR) && mem_wdata_o[6] && security_ok_o;
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("security flag not written");

  property p_keep_unlock;
    sys_reset_i |=> (security_ok_o == $past(security_ok_o));
  endproperty
  a_keep_unlock: assert property (p_keep_unlock) else $error("unlock lost on reset");

  property p_brk_high;
    (r.st == BRK_HIGH) |-> monitor_data_pin_o && !monitor_data_pin_oe_n_o;
  endproperty
  a_brk_high: assert property (p_brk_high) else $error("line not held high before break");
endmodule // monitor_serial_command_port

//--- core/serial_line_engine.sv
// half-duplex nrz transmitter, receiver and break detector on one wire
`timescale 1ns/1ps
module serial_line_engine (
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [16:0] bit_cycles_i,
  input  wire logic        line_i,
  input  wire logic        tx_start_i,
  input  wire logic        tx_break_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        hold_high_i,
  output logic             line_o,
  output logic             line_oe_n_o,
  output logic             tx_busy_o,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  input  wire logic        rx_ready_i,
  output logic             rx_break_o
);
  typedef struct packed {
    logic [1:0] sy;
    logic armed; logic rx_on; logic [16:0] rc; logic [3:0] rb; logic [9:0] rs;
    logic rv; logic [7:0] rd; logic brk;
    logic tx_on; logic [16:0] tc; logic [3:0] tb; logic [9:0] tsn;
  } eng_s;
  eng_s r;
  eng_s n;
  logic [9:0] rs_n;
  logic       line;
  assign line        = r.sy[1];
  assign line_o      = ~r.tsn[0];
  assign line_oe_n_o = !(r.tx_on || hold_high_i);
  assign tx_busy_o   = r.tx_on;
  assign rx_valid_o  = r.rv;
  assign rx_data_o   = r.rd;
  assign rx_break_o  = r.brk;
  always_comb begin
    n    = r;
    rs_n = {line, r.rs[9:1]};
    n.sy  = {r.sy[0], line_i};
    n.brk = 1'b0;
    if (rx_ready_i) n.rv = 1'b0;
    if (line) n.armed = 1'b1;
    // receiver starts no frame while this end drives the line
    if (!r.rx_on) begin
      if (r.armed && !line && !r.tx_on && !hold_high_i) begin
        n.rx_on = 1'b1;
        n.armed = 1'b0;
        n.rc    = bit_cycles_i >> 1;
        n.rb    = '0;
      end
    end else if (r.rc == '0) begin
      n.rs = rs_n;
      n.rb = r.rb + 4'h1;
      n.rc = bit_cycles_i - 17'h1;
      if (r.rb == '0 && line) begin
        n.rx_on = 1'b0;
      end else if (r.rb == mon_pkg::FRAME_LAST) begin
        n.rx_on = 1'b0;
        if (rs_n == '0) begin
          n.brk = 1'b1;
        end else if (line) begin
          n.rv = 1'b1;
          n.rd = rs_n[8:1];
        end
      end
    end else begin
      n.rc = r.rc - 17'h1;
    end
    if (tx_start_i && !r.tx_on) begin
      n.tx_on = 1'b1;
      n.tsn   = tx_break_i ? 10'h3FF : ~{1'b1, tx_data_i, 1'b0};
      n.tb    = '0;
      n.tc    = bit_cycles_i - 17'h1;
    end else if (r.tx_on) begin
      if (r.tc == '0) begin
        n.tsn = {1'b0, r.tsn[9:1]};
        n.tb  = r.tb + 4'h1;
        n.tc  = bit_cycles_i - 17'h1;
        if (r.tb == mon_pkg::FRAME_LAST) n.tx_on = 1'b0;
      end else begin
        n.tc = r.tc - 17'h1;
      end
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_tx_drives;
    r.tx_on && (r.tb == 4'h0) |-> !line_oe_n_o && !line_o;
  endproperty
  a_tx_drives: assert property (p_tx_drives) else $error("start bit not driven low");
endmodule // serial_line_engine

//--- dv/serial_host.sv
// host model: drives and samples the shared monitor data line
`timescale 1ns/1ps
module serial_host #(
  parameter int BIT = 278
) (
  input  wire logic core_clk_i,
  input  wire logic dev_o_i,
  input  wire logic dev_oe_n_i,
  output logic      line_o
);
  logic tx_r = 1'b1;

  // pulled-up wire: low while either side drives low
  assign line_o = tx_r & (dev_oe_n_i | dev_o_i);

  // ==========================================================
  // transmit one frame, each bit BIT clocks
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_i);
      tx_r <= f[i];
      repeat (BIT - 1) @(posedge core_clk_i);
    end
  endtask

  // ==========================================================
  // hold the line low for ten bits, then release it
  task automatic send_break();
    @(posedge core_clk_i);
    tx_r <= 1'b0;
    repeat (10 * BIT - 1) @(posedge core_clk_i);
    @(posedge core_clk_i);
    tx_r <= 1'b1;
  endtask

  // ==========================================================
  // bounded wait for a start bit, then sample ten bits mid-bit
  task automatic recv_byte(output logic [9:0] f, output logic ok, output int n);
    n = 0;
    while (line_o !== 1'b0 && n < 40 * BIT) begin
      @(negedge core_clk_i);
      n++;
    end
    ok = (n < 40 * BIT);
    repeat (BIT / 2) @(negedge core_clk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = line_o;
      if (i < 9) repeat (BIT) @(negedge core_clk_i);
    end
  endtask
endmodule // serial_host

//--- dv/testbench.sv
// self-checking bench for the monitor serial command port
`timescale 1ns/1ps
module testbench;
  localparam int BIT = 278;
  logic        core_clk_i = 1'b0;
  logic        reset_n_i  = 1'b0;
  logic [15:0] sp_r       = 16'h0000;
  logic [7:0]  rdata_r    = 8'h00;
  logic        sys_reset_r = 1'b0;
  logic        pin_o, oe_n, line, mem_rd, mem_wr, run, ill, sec_ok;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  mem [0:65535];
  int          checks     = 0;
  int          mismatches = 0;

  initial forever #10 core_clk_i = ~core_clk_i;

  monitor_serial_command_port u_monitor_serial_command_port (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .sys_reset_i(sys_reset_r),
    .monitor_data_pin_i(line), .monitor_data_pin_o(pin_o), .monitor_data_pin_oe_n_o(oe_n),
    .test_entry_voltage_i(1'b1), .divider_select_pin_i(1'b0), .mass_erase_i(1'b0),
    .sp_i(sp_r), .mem_addr_o(addr), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
    .mem_wdata_o(wdata), .mem_rdata_i(rdata_r), .run_o(run), .illegal_reset_o(ill),
    .security_ok_o(sec_ok));

  serial_host #(.BIT(BIT)) u_serial_host (
    .core_clk_i(core_clk_i), .dev_o_i(pin_o), .dev_oe_n_i(oe_n), .line_o(line));

  // ==========================================================
  // memory: read data valid the cycle after the read pulse
  always @(posedge core_clk_i) begin
    if (mem_rd) rdata_r <= mem[addr];
    if (mem_wr) mem[addr] <= wdata;
  end

  function automatic logic [7:0] exp_read(input logic [15:0] a, input logic unlocked);
    return (a >= mon_pkg::NVM_BASE && !unlocked) ? mon_pkg::INVALID : mem[a];
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic get(output logic [9:0] f, output int n);
    logic ok;
    u_serial_host.recv_byte(f, ok, n);
    check(ok, 1'b1);
    if (!ok) results();
  endtask

  // ==========================================================
  // one byte out, its echo back after the gap
  task automatic xfer(input logic [7:0] b);
    logic [9:0] f;
    int n;
    repeat (2 * BIT) @(posedge core_clk_i);
    u_serial_host.send_byte(b);
    get(f, n);
    check(f, {1'b1, b, 1'b0});
    check(n >= BIT && n <= 3 * BIT, 1'b1);
  endtask

  // power-on reset, held ten cycles
  task automatic power_on();
    reset_n_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge core_clk_i);
  endtask

  initial begin
    logic [9:0]  f;
    logic [15:0] a;
    int          n;
    void'($urandom(32'hE0E9));
    mem[16'h0040] = 8'h00;
    for (int i = 0; i < 8; i++) mem[mon_pkg::SEC_BASE + 16'(i)] = 8'($urandom);
    sp_r <= 16'($urandom);
    power_on();
    // security entry with the stored code, then the ready break
    for (int i = 0; i < 8; i++) xfer(mem[mon_pkg::SEC_BASE + 16'(i)]);
    get(f, n);
    check(f, 10'h000);
    check(n >= BIT, 1'b1);
    check(sec_ok, 1'b1);
    check(mem[16'h0040] & mon_pkg::FLAG_MASK, mon_pkg::FLAG_MASK);
    $display("test security done");
    // read of a random protected byte once unlocked
    a = 16'($urandom) | mon_pkg::NVM_BASE;
    mem[a] = 8'($urandom);
    xfer(mon_pkg::CMD_READ);
    xfer(a[15:8]);
    xfer(a[7:0]);
    get(f, n);
    check(f, {1'b1, exp_read(a, 1'b1), 1'b0});
    check(n >= 11 * BIT, 1'b1);
    $display("test read done");
    // a one-byte command, cancelled by a break inside its wait window
    xfer(mon_pkg::CMD_INDEXED_READ_CMD);
    repeat (BIT) @(posedge core_clk_i);
    u_serial_host.send_break();
    repeat (BIT) @(posedge core_clk_i);
    get(f, n);
    check(f, 10'h000);
    $display("test cancel done");
    // a reset other than power-on keeps the unlock and skips security entry
    repeat (2 * BIT) @(posedge core_clk_i);
    sys_reset_r <= 1'b1;
    @(posedge core_clk_i);
    sys_reset_r <= 1'b0;
    get(f, n);
    check(f, 10'h000);
    check(n >= 2 * BIT, 1'b1);
    check(sec_ok, 1'b1);
    $display("test system reset done");
    // a second power-on reset drops the unlock; no ready break before the code
    repeat (2 * BIT) @(posedge core_clk_i);
    power_on();
    repeat (BIT) @(posedge core_clk_i);
    check(sec_ok, 1'b0);
    check(oe_n, 1'b1);
    $display("test power-on reset done");
    results();
  end
endmodule // testbench
